/* File: rtl/pmc_cfg.svh */
`ifndef PMC_CFG_SVH
`define PMC_CFG_SVH

// command code and byte lanes of the configuration word
`define PMC_CMD_CODE 8'h01
`define PMC_CFG_RESET 16'h0000
`define PMC_LOW_MASK 8'hFF
`define PMC_HIGH_MASK 8'h37

// field positions within the 16-bit word
`define PMC_INTERVAL_HI 7
`define PMC_INTERVAL_LO 6
`define PMC_ITLEN_HI 5
`define PMC_ITLEN_LO 4
`define PMC_PULSES_HI 3
`define PMC_PULSES_LO 2
`define PMC_UNIT_BIT 1
`define PMC_GAIN_BIT 0
`define PMC_SENS_BIT 13
`define PMC_XTALK_BIT 12
`define PMC_DRIVE_HI 10
`define PMC_DRIVE_LO 8

// timing, in its own units
`define PMC_CLK_MHZ 200
`define PMC_INTERVAL0_MS 50
`define PMC_INTERVAL1_MS 100
`define PMC_INTERVAL2_MS 200
`define PMC_INTERVAL3_MS 400
`define PMC_UNIT_SHORT_US 25
`define PMC_UNIT_LONG_US 50

// result width at 1T, unity gain, narrow mode
`define PMC_BASE_BITS 12

`endif

/* File: rtl/pmc_pkg.sv */
package pmc_pkg;

    // measurement sequencer states
    typedef enum logic [1:0] {
        PMC_WAIT = 2'b00,
        PMC_PULSE = 2'b01,
        PMC_GAP = 2'b10
    } pmc_seq_t;

    // whole state of the repeat timer
    typedef struct packed {
        logic [31:0] count;
        logic tick;
    } pmc_timer_state_t;

    // whole state of the top module
    typedef struct packed {
        logic [15:0] cfg;
        logic [15:0] act;
        pmc_seq_t seq;
        logic [3:0] pulses_left;
        logic [17:0] dur;
        logic emitter_on;
        logic meas_start;
        logic meas_done;
        logic meas_busy;
        logic [4:0] drive_ma;
        logic [15:0] max_count;
        logic [7:0] rdata;
    } pmc_state_t;

endpackage

/* File: rtl/pmc_timer.sv */
`timescale 1ns/1ps

module pmc_timer (
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // control
    input wire logic run,
    input wire logic [31:0] load,
    // event
    output logic tick
);

    pmc_pkg::pmc_timer_state_t t;
    pmc_pkg::pmc_timer_state_t next_t;

    // reload on expiry, so a new interval takes effect one period later
    always_comb
    begin
        next_t = t;
        next_t.tick = 1'b0;
        if (!run)
            next_t.count = 32'h00000000;
        else if (t.count == 32'h00000000)
        begin
            next_t.tick = 1'b1;
            next_t.count = load - 32'h00000001;
        end
        else
            next_t.count = t.count - 32'h00000001;
    end

    // counter and tick live in one state register
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            t <= '0;
        else
            t <= next_t;
    end

    // tick comes straight from the register
    assign tick = t.tick;

endmodule

/* File: rtl/pmc_top.sv */
// How it works
// - bits 7:6 pick the repeat interval; code 2 is 200 ms; reset 0.
// - bits 5:4 set integration length 1, 2, 4 or 8 pulse units.
// - bit 1 picks pulse unit: clear is short unit, set is 50 us.
// - bit 0 picks ADC gain: clear unity, set double.
// - bit 13 picks ADC sensitivity: clear normal, set high.
// - bit 12 turns crosstalk cancellation on; off after reset.
// - bits 10:8 pick laser current 7,9,11,12,15,17,19,20 mA.
// - measurements run only while sensor power enable is set.
// - wide mode scales maximum count from 12 to 16 bits.
`timescale 1ns/1ps
`include "pmc_cfg.svh"

module pmc_top #(
    parameter int unsigned INTERVAL0_CYC = `PMC_INTERVAL0_MS * 1000 * `PMC_CLK_MHZ,
    parameter int unsigned INTERVAL1_CYC = `PMC_INTERVAL1_MS * 1000 * `PMC_CLK_MHZ,
    parameter int unsigned INTERVAL2_CYC = `PMC_INTERVAL2_MS * 1000 * `PMC_CLK_MHZ,
    parameter int unsigned INTERVAL3_CYC = `PMC_INTERVAL3_MS * 1000 * `PMC_CLK_MHZ,
    parameter int unsigned UNIT_SHORT_CYC = `PMC_UNIT_SHORT_US * `PMC_CLK_MHZ,
    parameter int unsigned UNIT_LONG_CYC = `PMC_UNIT_LONG_US * `PMC_CLK_MHZ
) (
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // command register port
    input wire logic [7:0] reg_cmd,
    input wire logic reg_high,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // bits held in the neighbouring configuration word
    input wire logic sensor_power_en,
    input wire logic wide_range_en,
    // measurement front end
    output logic emitter_on,
    output logic [2:0] emitter_drive_sel,
    output logic [4:0] emitter_drive_ma,
    output logic adc_gain_sel,
    output logic adc_sensitivity_sel,
    output logic crosstalk_cancel_en,
    output logic meas_start,
    output logic meas_done,
    output logic meas_busy,
    output logic [15:0] result_max_count
);

    pmc_pkg::pmc_state_t s;
    pmc_pkg::pmc_state_t next_s;
    logic tick;
    logic [31:0] interval_load;

    // interval code to clock cycles
    function automatic logic [31:0] interval_cycles(input logic [1:0] sel);
        logic [31:0] c;
        unique case (sel)
            2'b00: c = INTERVAL0_CYC[31:0];
            2'b01: c = INTERVAL1_CYC[31:0];
            2'b10: c = INTERVAL2_CYC[31:0];
            2'b11: c = INTERVAL3_CYC[31:0];
        endcase
        return c;
    endfunction

    // cycles of one pulse unit
    function automatic logic [17:0] unit_cycles(input logic long_unit);
        return long_unit ? UNIT_LONG_CYC[17:0] : UNIT_SHORT_CYC[17:0];
    endfunction

    // integration length: unit times 1, 2, 4 or 8
    function automatic logic [17:0] integ_cycles(input logic [15:0] w);
        return unit_cycles(w[`PMC_UNIT_BIT]) << w[`PMC_ITLEN_HI:`PMC_ITLEN_LO];
    endfunction

    // laser current in mA per drive code
    function automatic logic [4:0] drive_ma(input logic [2:0] sel);
        logic [4:0] m;
        unique case (sel)
            3'h0: m = 5'h07;
            3'h1: m = 5'h09;
            3'h2: m = 5'h0B;
            3'h3: m = 5'h0C;
            3'h4: m = 5'h0F;
            3'h5: m = 5'h11;
            3'h6: m = 5'h13;
            3'h7: m = 5'h14;
        endcase
        return m;
    endfunction

    // largest result count; narrow mode stays at the base width
    function automatic logic [15:0] max_count(input logic [15:0] w, input logic wide);
        logic [4:0] bits;
        logic [16:0] full;
        bits = 5'(`PMC_BASE_BITS);
        if (wide)
            bits = bits + 5'(w[`PMC_ITLEN_HI:`PMC_ITLEN_LO]) + 5'(w[`PMC_GAIN_BIT]);
        full = (17'h00001 << bits) - 17'h00001;
        return full[15:0];
    endfunction

    // interval is taken from the live word at each reload
    assign interval_load = interval_cycles(s.cfg[`PMC_INTERVAL_HI:`PMC_INTERVAL_LO]);

    // repeat timer stops while the sensor is shut down
    pmc_timer u_timer (
        .mclk(mclk),
        .reset_n(reset_n),
        .run(sensor_power_en),
        .load(interval_load),
        .tick(tick)
    );

    always_comb
    begin
        next_s = s;
        next_s.meas_start = 1'b0;
        next_s.meas_done = 1'b0;

        // register writes; reserved bits are dropped and read as zero
        if (reg_wr && reg_cmd == `PMC_CMD_CODE)
        begin
            if (reg_high)
                next_s.cfg[15:8] = reg_wdata & `PMC_HIGH_MASK;
            else
                next_s.cfg[7:0] = reg_wdata & `PMC_LOW_MASK;
        end

        // reads of other command codes answer zero
        if (reg_rd)
        begin
            if (reg_cmd == `PMC_CMD_CODE)
                next_s.rdata = reg_high ? s.cfg[15:8] : s.cfg[7:0];
            else
                next_s.rdata = 8'h00;
        end

        // measurement sequencer
        unique case (s.seq)
            pmc_pkg::PMC_WAIT:
            begin
                next_s.emitter_on = 1'b0;
                if (tick && sensor_power_en)
                begin
                    // snapshot so a write mid-measurement waits its turn
                    next_s.act = s.cfg;
                    next_s.drive_ma = drive_ma(s.cfg[`PMC_DRIVE_HI:`PMC_DRIVE_LO]);
                    next_s.max_count = max_count(s.cfg, wide_range_en);
                    next_s.pulses_left = (4'h1 << s.cfg[`PMC_PULSES_HI:`PMC_PULSES_LO])
                        - 4'h1;
                    next_s.dur = integ_cycles(s.cfg) - 18'h00001;
                    next_s.emitter_on = 1'b1;
                    next_s.meas_start = 1'b1;
                    next_s.meas_busy = 1'b1;
                    next_s.seq = pmc_pkg::PMC_PULSE;
                end
            end
            pmc_pkg::PMC_PULSE:
            begin
                if (s.dur != 18'h00000)
                    next_s.dur = s.dur - 18'h00001;
                else if (s.pulses_left == 4'h0)
                begin
                    next_s.emitter_on = 1'b0;
                    next_s.meas_done = 1'b1;
                    next_s.meas_busy = 1'b0;
                    next_s.seq = pmc_pkg::PMC_WAIT;
                end
                else
                begin
                    // one pulse unit dark between pulses
                    next_s.emitter_on = 1'b0;
                    next_s.dur = unit_cycles(s.act[`PMC_UNIT_BIT]) - 18'h00001;
                    next_s.seq = pmc_pkg::PMC_GAP;
                end
            end
            pmc_pkg::PMC_GAP:
            begin
                if (s.dur != 18'h00000)
                    next_s.dur = s.dur - 18'h00001;
                else
                begin
                    next_s.emitter_on = 1'b1;
                    next_s.pulses_left = s.pulses_left - 4'h1;
                    next_s.dur = integ_cycles(s.act) - 18'h00001;
                    next_s.seq = pmc_pkg::PMC_PULSE;
                end
            end
            default:
            begin
                next_s.emitter_on = 1'b0;
                next_s.seq = pmc_pkg::PMC_WAIT;
            end
        endcase

        // shutdown aborts a measurement without a done pulse
        if (!sensor_power_en)
        begin
            next_s.emitter_on = 1'b0;
            next_s.meas_start = 1'b0;
            next_s.meas_busy = 1'b0;
            next_s.seq = pmc_pkg::PMC_WAIT;
        end
    end

    // single state register
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s <= '0;
            s.cfg <= `PMC_CFG_RESET;
            s.act <= `PMC_CFG_RESET;
            s.drive_ma <= 5'h07;
            s.max_count <= 16'h0FFF;
            s.seq <= pmc_pkg::PMC_WAIT;
        end
        else
            s <= next_s;
    end

    // outputs come straight from the state register
    assign reg_rdata = s.rdata;
    assign emitter_on = s.emitter_on;
    assign emitter_drive_sel = s.act[`PMC_DRIVE_HI:`PMC_DRIVE_LO];
    assign emitter_drive_ma = s.drive_ma;
    assign adc_gain_sel = s.act[`PMC_GAIN_BIT];
    assign adc_sensitivity_sel = s.act[`PMC_SENS_BIT];
    assign crosstalk_cancel_en = s.act[`PMC_XTALK_BIT];
    assign meas_start = s.meas_start;
    assign meas_done = s.meas_done;
    assign meas_busy = s.meas_busy;
    assign result_max_count = s.max_count;

endmodule

/* File: sim/pmc_host.sv */
`timescale 1ns/1ps
module pmc_host (
    // clock
    input wire logic mclk,
    // command port, host side
    output logic [7:0] reg_cmd,
    output logic reg_high,
    output logic reg_wr,
    output logic [7:0] reg_wdata,
    output logic reg_rd
);
    // bus idle until the first access
    initial {reg_cmd, reg_high, reg_wr, reg_rd, reg_wdata} = 19'h00000;
    // one strobed byte, launched and dropped at falling edges
    task automatic access(input logic [7:0] c, input logic h, input logic w, input logic [7:0] d);
        @(negedge mclk);
        {reg_cmd, reg_high, reg_wr, reg_rd, reg_wdata} = {c, h, w, !w, d};
        @(negedge mclk);
        {reg_wr, reg_rd, reg_wdata} = {2'b00, ~d}; // released data must not look stale
    endtask
endmodule

/* File: sim/pmc_top_assertions.sv */
`timescale 1ns/1ps
`include "pmc_cfg.svh"
module pmc_top_assertions #(
    parameter int unsigned UNIT_SHORT_CYC = 4,
    parameter int unsigned UNIT_LONG_CYC = 8
) (
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // register port
    input wire logic [7:0] reg_cmd,
    input wire logic reg_high,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // mode inputs and front end
    input wire logic sensor_power_en,
    input wire logic wide_range_en,
    input wire logic emitter_on,
    input wire logic [2:0] emitter_drive_sel,
    input wire logic [4:0] emitter_drive_ma,
    input wire logic adc_gain_sel,
    input wire logic adc_sensitivity_sel,
    input wire logic crosstalk_cancel_en,
    input wire logic meas_start,
    input wire logic meas_done,
    input wire logic meas_busy,
    input wire logic [15:0] result_max_count
);
    localparam logic [4:0] MA [8] = '{5'h07, 5'h09, 5'h0B, 5'h0C, 5'h0F, 5'h11, 5'h13, 5'h14};
    logic [15:0] word, wprev, snap;
    logic [9:0] hi_cnt;
    logic [3:0] pcnt;
    logic e_d;
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!reset_n);
    // shadow word; wprev is what the design saw at the last edge
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            {word, wprev, snap, hi_cnt, pcnt, e_d} <= '0;
        else
        begin
            if (reg_wr && reg_cmd == `PMC_CMD_CODE && reg_high)
                word[15:8] <= reg_wdata & `PMC_HIGH_MASK;
            if (reg_wr && reg_cmd == `PMC_CMD_CODE && !reg_high)
                word[7:0] <= reg_wdata;
            wprev <= word;
            if (meas_start)
                snap <= wprev;
            hi_cnt <= emitter_on ? hi_cnt + 10'h001 : 10'h000;
            pcnt <= meas_start ? 4'h1 : pcnt + 4'(emitter_on && !e_d);
            e_d <= emitter_on;
        end
    end
    a_read_data: assert property (
        reg_rd |=> reg_rdata == ($past(reg_cmd) != `PMC_CMD_CODE ? 8'h00 :
        $past(reg_high) ? wprev[15:8] : wprev[7:0])) else $error("read data wrong");
    a_snap_fields: assert property (
        meas_start |-> {emitter_drive_sel, adc_gain_sel, adc_sensitivity_sel, crosstalk_cancel_en}
        == {wprev[10:8], wprev[0], wprev[13], wprev[12]}) else $error("snapshot wrong");
    a_snap_hold: assert property (
        meas_busy && !meas_start |-> $stable(emitter_drive_sel) && $stable(adc_gain_sel)
        && $stable(crosstalk_cancel_en)) else $error("settings moved mid-measurement");
    a_drive_map: assert property (
        emitter_drive_ma == MA[emitter_drive_sel]) else $error("drive current wrong");
    a_max_count: assert property (
        meas_start |-> result_max_count == ($past(wide_range_en) ? 16'((17'h1 <<
        (`PMC_BASE_BITS + wprev[5:4] + wprev[0])) - 17'h1) : 16'h0FFF)) else $error("max count");
    a_power_off: assert property (
        !sensor_power_en |=> !emitter_on && !meas_busy) else $error("active while off");
    a_pulse_len: assert property (
        $fell(emitter_on) && sensor_power_en |-> hi_cnt ==
        (snap[1] ? UNIT_LONG_CYC : UNIT_SHORT_CYC) << snap[5:4]) else $error("pulse length");
    a_pulse_count: assert property (
        meas_done |-> pcnt == 4'h1 << snap[3:2]) else $error("pulse count wrong");
    c_done: cover property (meas_done);
    c_abort: cover property ($fell(meas_busy) && !meas_done);
    c_unmapped: cover property (reg_rd && reg_cmd != `PMC_CMD_CODE);
endmodule

/* File: sim/testbench.sv */
`timescale 1ns/1ps
`include "pmc_cfg.svh"
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin errors++; \
    $display("mismatch %s expected %0h seen %0h", n, e, s); end end
module testbench;
    localparam int US = 4;
    localparam int UL = 8;
    localparam int IV [4] = '{700, 800, 900, 1000};
    localparam logic [4:0] MA [8] = '{5'h07, 5'h09, 5'h0B, 5'h0C, 5'h0F, 5'h11, 5'h13, 5'h14};
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic sensor_power_en = 1'b0;
    logic wide_range_en = 1'b0;
    logic rd_d = 1'b0;
    logic [7:0] reg_cmd, reg_wdata, reg_rdata;
    logic reg_high, reg_wr, reg_rd, emitter_on, adc_gain_sel, adc_sensitivity_sel;
    logic crosstalk_cancel_en, meas_start, meas_done, meas_busy;
    logic [2:0] emitter_drive_sel;
    logic [4:0] emitter_drive_ma;
    logic [15:0] result_max_count;
    logic [23:0] ex, fe_seen;
    logic [7:0] rq [$];
    logic [23:0] mq [$];
    int errors = 0;
    int checked = 0;
    int cyc = 0;
    pmc_top #(.INTERVAL0_CYC(IV[0]), .INTERVAL1_CYC(IV[1]), .INTERVAL2_CYC(IV[2]),
        .INTERVAL3_CYC(IV[3]), .UNIT_SHORT_CYC(US), .UNIT_LONG_CYC(UL)) i_dut (.*);
    pmc_host i_host (.*);
    assign fe_seen = {emitter_drive_ma, adc_sensitivity_sel, crosstalk_cancel_en, adc_gain_sel,
        result_max_count};
    // 200 MHz clock
    initial forever #2.5 mclk = ~mclk;
    // cycle count and read-answer marker
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        rd_d <= reg_rd;
    end
    // hang guard, far above the longest sequence
    always @(negedge mclk)
        if (cyc > 40000)
        begin
            errors++;
            tally_and_finish();
        end
    // each result is matched with the oldest note
    always @(negedge mclk)
    begin
        if (rd_d)
        begin
            ex = {16'h0000, rq.pop_front()};
            `CHK("reg_rdata", ex[7:0], reg_rdata)
        end
        if (meas_start)
        begin
            ex = mq.pop_front();
            `CHK("front end", ex, fe_seen)
        end
    end
    function automatic logic [23:0] fe(input logic [15:0] w);
        return {MA[w[10:8]], w[13], w[12], w[0], wide_range_en ?
            16'((17'h1 << (`PMC_BASE_BITS + w[5:4] + w[0])) - 17'h1) : 16'h0FFF};
    endfunction
    // reserved bits written unmasked as w gives them; they must read back as zero
    task automatic set_cfg(input logic [15:0] w);
        i_host.access(8'h01, 1'b0, 1'b1, w[7:0]);
        i_host.access(8'h01, 1'b1, 1'b1, w[15:8]);
        rq.push_back(w[7:0]);
        i_host.access(8'h01, 1'b0, 1'b0, 8'h00);
        rq.push_back(w[15:8] & `PMC_HIGH_MASK);
        i_host.access(8'h01, 1'b1, 1'b0, 8'h00);
    endtask
    task automatic run_meas(input logic [15:0] w);
        int t0;
        int u;
        set_cfg(w);
        mq.push_back(fe(w));
        u = w[1] ? UL : US;
        sensor_power_en = 1'b1;
        @(negedge mclk iff meas_start);
        t0 = cyc;
        @(negedge mclk iff meas_done);
        `CHK("busy", (u << w[5:4]) * (1 << w[3:2]) + ((1 << w[3:2]) - 1) * u, cyc - t0)
        sensor_power_en = 1'b0;
    endtask
    // start-to-start spacing, a write mid-measurement, then an abort
    task automatic run_period(input logic [1:0] c);
        logic [15:0] w;
        int t0;
        w = 16'($urandom);
        w[7:6] = c;
        set_cfg(w);
        mq.push_back(fe(w));
        sensor_power_en = 1'b1;
        @(negedge mclk iff meas_start);
        t0 = cyc;
        w[10:8] = w[10:8] + 3'h1;
        i_host.access(8'h01, 1'b1, 1'b1, w[15:8]);
        mq.push_back(fe(w));
        @(negedge mclk iff meas_start);
        `CHK("interval", IV[c], cyc - t0)
        sensor_power_en = 1'b0;
    endtask
    task automatic tally_and_finish();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // reset, then the scenarios in order
    initial
    begin
        logic [15:0] w;
        void'($urandom(71));
        repeat (5) @(negedge mclk);
        reset_n = 1'b1;
        `CHK("drive mA", 5'h07, emitter_drive_ma)
        `CHK("max count", 16'h0FFF, result_max_count)
        // unmapped code: write dropped, read gives zero, word still at reset
        i_host.access(8'h02, 1'b0, 1'b1, 8'hFF);
        rq.push_back(8'h00);
        i_host.access(8'h02, 1'b0, 1'b0, 8'h00);
        rq.push_back(8'h00);
        i_host.access(8'h01, 1'b0, 1'b0, 8'h00);
        rq.push_back(8'h00);
        i_host.access(8'h01, 1'b1, 1'b0, 8'h00);
        for (int i = 0; i < 16; i++)
        begin
            w = 16'($urandom);
            w[10:8] = i[2:0];
            wide_range_en = i[3];
            run_meas(w);
        end
        for (int c = 0; c < 4; c++)
            run_period(c[1:0]);
        // unmapped read after a nonzero answer must still give zero
        set_cfg(16'hFFFF);
        rq.push_back(8'h00);
        i_host.access(8'h02, 1'b0, 1'b0, 8'h00);
        tally_and_finish();
    end
endmodule
bind pmc_top pmc_top_assertions #(.UNIT_SHORT_CYC(UNIT_SHORT_CYC), .UNIT_LONG_CYC(UNIT_LONG_CYC))
    i_chk (.*);
